// [include/gbc_regs.vh]
`ifndef GBC_REGS_VH
`define GBC_REGS_VH
// apb register byte offsets
`define GBC_CTRL_OFS      8'h00
`define GBC_STAT_OFS      8'h04
`define GBC_STB_OFS       8'h08
`define GBC_MODE_OFS      8'h0c
`define GBC_CHAN_OFS      8'h10
`define GBC_TIME_OFS      8'h14
`define GBC_ALARM_OFS     8'h18
`define GBC_IOPORT_OFS    8'h1c
`define GBC_SRQ_OFS       8'h20
// ctrl field positions
`define GBC_CTRL_START_BIT 8
`define GBC_CTRL_STOP_BIT  9
// mode field positions
`define GBC_MODE_POLE_LSB  0
`define GBC_MODE_PROG_LSB  4
`define GBC_MODE_DISP_LSB  8
`define GBC_MODE_TRIG_LSB  12
`define GBC_MODE_PFX_BIT   16
`define GBC_MODE_EOI_BIT   17
// bus command bytes (low seven bits)
`define GBC_CMD_GTL       7'h01
`define GBC_CMD_SDC       7'h04
`define GBC_CMD_GET       7'h08
`define GBC_CMD_LLO       7'h11
`define GBC_CMD_DCL       7'h14
`define GBC_CMD_SPE       7'h18
`define GBC_CMD_SPD       7'h19
`define GBC_CMD_UNL       7'h3f
`define GBC_CMD_UNT       7'h5f
`define GBC_GRP_LISTEN    2'h1
`define GBC_GRP_TALK      2'h2
// modes
`define GBC_PROG_STEP     2'h0
`define GBC_PROG_CONT     2'h2
`define GBC_TRIG_START_GET 3'h2
`define GBC_TRIG_STOP_GET  3'h3
// reset / clear values
`define GBC_POLES_RST     3'h2
`define GBC_PROG_RST      2'h0
`define GBC_DISP_RST      3'h0
`define GBC_TRIG_RST      3'h6
`define GBC_PFX_RST       1'h0
`define GBC_EOI_RST       1'h0
`define GBC_FIRST_RST     8'h01
`define GBC_LAST_RST      8'h01
`define GBC_DCHAN_RST     8'h01
`define GBC_SRQ_RST       8'h00
`define GBC_STB_RST       8'h00
`define GBC_ADDR_RST      5'h11
`define GBC_ALARM_RST     24'h000000
`define GBC_IOPORT_RST    4'h0
// settle and interval times held in milliseconds
`define GBC_SETTLE_MS_RST 16'h000a
`define GBC_INTVL_MS_RST  16'h000a
`endif

// [verilog/gbc_bus_cmd_handler.v]
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "gbc_regs.vh"

// Functional notes
// - bytes taken with attention low are decoded as universal or addressed commands
// - bytes with attention high are data, passed on only when addressed to listen
// - device clear erases program memory and resets buffer pointer to first location
// - device clear restores poles, first/last channel, program, display defaults
// - settle and interval times return to ten milliseconds
// - defaults: no service requests, prefixed data, end-or-identify on last byte
// - local lockout locks front panel, only while remote enable already asserted
// - poll enabled, talker, attention released: status byte driven onto data lines
// - poll disable leaves serial poll state and stops presenting status byte
// - status byte reads zero when no status condition bits are set
// - untalk drops talker role, unlisten drops listener role
// - addressed commands act only when listen address matches configured address
// - selected clear erases memory, resets buffer and display pointers
// - selected clear disables alarm, stops alarm timer, port low, channels open
// - selected clear selects channel display, prefixed output, step mode, no requests
// - continuous mode with start-on-trigger: trigger starts scan, run indicator on
// - stop-on-trigger mode: trigger stops scan, run indicator off
// - any valid device command during a scan stops the scan
// - group execute trigger is accepted without listen addressing
// - go-to-local leaves remote mode
// - go-to-local keeps lockout; remote enable release ends lockout and remote
module gbc_bus_cmd_handler (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // accepted bytes from the acceptor handshake (pclk domain)
    input  wire [7:0]  rx_byte,
    input  wire        rx_atn,
    input  wire        rx_strobe,
    // bus management pins, active low, asynchronous
    input  wire        atn_n,
    input  wire        ren_n,
    // device-dependent command parser
    input  wire        cmd_exec_valid,
    output reg  [7:0]  ddc_byte,
    output reg         ddc_strobe,
    // talker data drive toward the bus transceiver
    output reg  [7:0]  talk_byte,
    output reg         talk_oe,
    // interface state
    output reg         remote,
    output reg         lockout,
    output reg         talker,
    output reg         listener,
    output reg         spoll_active,
    output reg         run_led,
    // clear action pulses
    output reg         mem_clear,
    output reg         buf_ptr_rst,
    output reg         disp_ptr_rst,
    output reg         open_all,
    output reg         alarm_off,
    // settings
    output reg  [2:0]  poles,
    output reg  [1:0]  prog_mode,
    output reg  [2:0]  disp_mode,
    output reg  [2:0]  trig_mode,
    output reg         prefix_off,
    output reg         eoi_off,
    output reg  [7:0]  first_chan,
    output reg  [7:0]  last_chan,
    output reg  [7:0]  disp_chan,
    output reg  [15:0] settle_ms,
    output reg  [15:0] interval_ms,
    output reg  [23:0] alarm_time,
    output reg  [3:0]  io_port,
    output reg  [7:0]  srq_mask
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages one and two agree
    reg [2:0] atn_sync_reg;
    reg [2:0] ren_sync_reg;
    reg       atn_flt_reg;
    reg       ren_flt_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            atn_sync_reg <= 3'h7;
            ren_sync_reg <= 3'h7;
            atn_flt_reg  <= 1'b0;
            ren_flt_reg  <= 1'b0;
        end else begin
            atn_sync_reg <= {atn_sync_reg[1:0], atn_n};
            ren_sync_reg <= {ren_sync_reg[1:0], ren_n};
            // stage zero is never looked at here, only shifted on
            if (atn_sync_reg[1] == atn_sync_reg[2])
                atn_flt_reg <= ~atn_sync_reg[2];
            if (ren_sync_reg[1] == ren_sync_reg[2])
                ren_flt_reg <= ~ren_sync_reg[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode
    wire [6:0] cmd       = rx_byte[6:0];
    wire       cmd_byte  = rx_strobe & rx_atn;
    wire       data_byte = rx_strobe & ~rx_atn;
    wire [4:0] my_addr;
    wire       is_mla    = (cmd[6:5] == `GBC_GRP_LISTEN) && (cmd != `GBC_CMD_UNL);
    wire       is_mta    = (cmd[6:5] == `GBC_GRP_TALK) && (cmd != `GBC_CMD_UNT);
    wire       addr_hit  = (cmd[4:0] == my_addr);

    wire do_dcl = cmd_byte && (cmd == `GBC_CMD_DCL);
    wire do_sdc = cmd_byte && (cmd == `GBC_CMD_SDC) && listener;
    wire do_gtl = cmd_byte && (cmd == `GBC_CMD_GTL) && listener;
    wire do_get = cmd_byte && (cmd == `GBC_CMD_GET);
    wire do_llo = cmd_byte && (cmd == `GBC_CMD_LLO) && ren_flt_reg;
    wire do_clr = do_dcl | do_sdc;

    // trigger only starts from continuous mode with start-on-trigger
    wire get_start = do_get && (prog_mode == `GBC_PROG_CONT) &&
                     (trig_mode == `GBC_TRIG_START_GET);
    wire get_stop  = do_get && (trig_mode == `GBC_TRIG_STOP_GET);

    ////////////////////////////////////////////////////////////////////////
    // apb access: one wait state, answer on the second access cycle
    wire        acc_done = psel & penable & pready;
    wire        wr_en    = acc_done & pwrite;
    wire        mapped   = (paddr <= `GBC_SRQ_OFS) && (paddr[1:0] == 2'h0);
    reg  [4:0]  addr_reg;
    reg  [7:0]  stb_reg;
    reg  [31:0] rd_next;
    reg         sw_start;
    reg         sw_stop;

    assign my_addr = addr_reg;

    // read mux
    always @* begin
        rd_next = 32'h00000000;
        case (paddr)
            `GBC_CTRL_OFS:   rd_next = {27'h0000000, addr_reg};
            `GBC_STAT_OFS:   rd_next = {25'h0000000, ren_flt_reg, run_led, spoll_active,
                                        listener, talker, lockout, remote};
            `GBC_STB_OFS:    rd_next = {24'h000000, stb_reg};
            `GBC_MODE_OFS:   rd_next = {14'h0000, eoi_off, prefix_off, 1'b0, trig_mode, 1'b0,
                                        disp_mode, 2'h0, prog_mode, 1'b0, poles};
            `GBC_CHAN_OFS:   rd_next = {8'h00, disp_chan, last_chan, first_chan};
            `GBC_TIME_OFS:   rd_next = {interval_ms, settle_ms};
            `GBC_ALARM_OFS:  rd_next = {8'h00, alarm_time};
            `GBC_IOPORT_OFS: rd_next = {28'h0000000, io_port};
            `GBC_SRQ_OFS:    rd_next = {24'h000000, srq_mask};
            default:         rd_next = 32'h00000000;
        endcase
    end

    // bus handshake
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel & penable & ~pready)
                prdata <= pwrite ? 32'h00000000 : rd_next;
        end
    end

    // software scan start and stop strobes
    always @* begin
        sw_start = wr_en && (paddr == `GBC_CTRL_OFS) && pwdata[`GBC_CTRL_START_BIT];
        sw_stop  = wr_en && (paddr == `GBC_CTRL_OFS) && pwdata[`GBC_CTRL_STOP_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // settings: software writes, bus clears restore defaults
    // a clear wins over a same-cycle write so the known state is exact
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg    <= `GBC_ADDR_RST;
            stb_reg     <= `GBC_STB_RST;
            poles       <= `GBC_POLES_RST;
            prog_mode   <= `GBC_PROG_RST;
            disp_mode   <= `GBC_DISP_RST;
            trig_mode   <= `GBC_TRIG_RST;
            prefix_off  <= `GBC_PFX_RST;
            eoi_off     <= `GBC_EOI_RST;
            first_chan  <= `GBC_FIRST_RST;
            last_chan   <= `GBC_LAST_RST;
            disp_chan   <= `GBC_DCHAN_RST;
            settle_ms   <= `GBC_SETTLE_MS_RST;
            interval_ms <= `GBC_INTVL_MS_RST;
            alarm_time  <= `GBC_ALARM_RST;
            io_port     <= `GBC_IOPORT_RST;
            srq_mask    <= `GBC_SRQ_RST;
        end else if (do_clr) begin
            poles       <= `GBC_POLES_RST;
            first_chan  <= `GBC_FIRST_RST;
            last_chan   <= `GBC_LAST_RST;
            prog_mode   <= `GBC_PROG_RST;
            disp_mode   <= `GBC_DISP_RST;
            disp_chan   <= `GBC_DCHAN_RST;
            trig_mode   <= `GBC_TRIG_RST;
            settle_ms   <= `GBC_SETTLE_MS_RST;
            interval_ms <= `GBC_INTVL_MS_RST;
            srq_mask    <= `GBC_SRQ_RST;
            prefix_off  <= `GBC_PFX_RST;
            eoi_off     <= `GBC_EOI_RST;
            if (do_sdc) begin
                alarm_time <= `GBC_ALARM_RST;
                io_port    <= `GBC_IOPORT_RST;
            end
        end else if (wr_en) begin
            case (paddr)
                `GBC_CTRL_OFS:   addr_reg <= pwdata[4:0];
                `GBC_STB_OFS:    stb_reg  <= pwdata[7:0];
                `GBC_MODE_OFS: begin
                    poles      <= pwdata[`GBC_MODE_POLE_LSB +: 3];
                    prog_mode  <= pwdata[`GBC_MODE_PROG_LSB +: 2];
                    disp_mode  <= pwdata[`GBC_MODE_DISP_LSB +: 3];
                    trig_mode  <= pwdata[`GBC_MODE_TRIG_LSB +: 3];
                    prefix_off <= pwdata[`GBC_MODE_PFX_BIT];
                    eoi_off    <= pwdata[`GBC_MODE_EOI_BIT];
                end
                `GBC_CHAN_OFS: begin
                    first_chan <= pwdata[7:0];
                    last_chan  <= pwdata[15:8];
                    disp_chan  <= pwdata[23:16];
                end
                `GBC_TIME_OFS: begin
                    settle_ms   <= pwdata[15:0];
                    interval_ms <= pwdata[31:16];
                end
                `GBC_ALARM_OFS:  alarm_time <= pwdata[23:0];
                `GBC_IOPORT_OFS: io_port    <= pwdata[3:0];
                `GBC_SRQ_OFS:    srq_mask   <= pwdata[7:0];
                default:         addr_reg   <= addr_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clear action pulses, one cycle each
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_clear    <= 1'b0;
            buf_ptr_rst  <= 1'b0;
            disp_ptr_rst <= 1'b0;
            open_all     <= 1'b0;
            alarm_off    <= 1'b0;
        end else begin
            mem_clear    <= do_clr;
            buf_ptr_rst  <= do_clr;
            disp_ptr_rst <= do_sdc;
            open_all     <= do_sdc;
            alarm_off    <= do_sdc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // addressing, remote and lockout
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            talker   <= 1'b0;
            listener <= 1'b0;
            remote   <= 1'b0;
            lockout  <= 1'b0;
        end else begin
            if (cmd_byte) begin
                if (cmd == `GBC_CMD_UNT)
                    talker <= 1'b0;
                else if (is_mta)
                    talker <= addr_hit;            // other talk address drops us
                if (cmd == `GBC_CMD_UNL)
                    listener <= 1'b0;
                else if (is_mla && addr_hit)
                    listener <= 1'b1;
            end
            if (!ren_flt_reg) begin
                remote  <= 1'b0;
                lockout <= 1'b0;
            end else begin
                if (cmd_byte && is_mla && addr_hit)
                    remote <= 1'b1;
                else if (do_gtl)
                    remote <= 1'b0;
                if (do_llo)
                    lockout <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial poll; status byte is software-owned and resets to zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spoll_active <= 1'b0;
            talk_byte    <= 8'h00;
            talk_oe      <= 1'b0;
        end else begin
            if (cmd_byte && (cmd == `GBC_CMD_SPE))
                spoll_active <= 1'b1;
            else if (cmd_byte && (cmd == `GBC_CMD_SPD))
                spoll_active <= 1'b0;
            // drive only with attention released, so commands are never clobbered
            talk_oe   <= spoll_active & talker & ~atn_flt_reg;
            talk_byte <= (spoll_active & talker) ? stb_reg : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // device-dependent data pass-through and scan run state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ddc_byte   <= 8'h00;
            ddc_strobe <= 1'b0;
            run_led    <= 1'b0;
        end else begin
            ddc_strobe <= data_byte & listener;
            if (data_byte & listener)
                ddc_byte <= rx_byte;
            // any stop source beats a start in the same cycle
            if (do_clr || get_stop || sw_stop || cmd_exec_valid)
                run_led <= 1'b0;
            else if (get_start || sw_start)
                run_led <= 1'b1;
        end
    end

endmodule // gbc_bus_cmd_handler

// [sim/gbc_ctlr_model.sv]
`timescale 1ns/1ps
`include "gbc_regs.vh"
// bus controller stand-in: accepted bytes and management lines
module gbc_ctlr_model (
    // clock
    input  wire       pclk,
    // accepted byte path and management pins
    output reg  [7:0] rx_byte,
    output reg        rx_atn,
    output reg        rx_strobe,
    output reg        atn_n,
    output reg        ren_n
);
    ////////////////////////////////////////////////////////////////////////////
    // idle bus: attention and remote enable both false
    initial begin
        rx_byte   = 8'h00;
        rx_atn    = 1'b0;
        rx_strobe = 1'b0;
        atn_n     = 1'b1;
        ren_n     = 1'b1;
    end
    // one byte; gap makes the controller prompt or slow
    task send(input bit atn, input [7:0] b, input int gap);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        atn_n     <= ~atn;
        rx_atn    <= atn;
        rx_byte   <= b;
        rx_strobe <= 1'b1;
        @(posedge pclk);
        rx_strobe <= 1'b0;
        rx_byte   <= ~b; // released lines must not look like a held copy
    endtask
    // remote enable, then room for the pin synchroniser to settle
    task set_ren(input bit v);
        @(posedge pclk);
        ren_n <= v;
        repeat (8) @(posedge pclk);
    endtask
    // attention, poll enable, talk address, then attention released
    task poll_start(input [4:0] a);
        send(1'b1, {1'b0, `GBC_CMD_SPE}, 0);
        send(1'b1, {3'b010, a}, 1);
        @(posedge pclk);
        atn_n <= 1'b1;
    endtask
    // attention again with poll disable
    task poll_end;
        send(1'b1, {1'b0, `GBC_CMD_SPD}, 0);
    endtask
endmodule // gbc_ctlr_model

// [sim/gbc_bus_cmd_handler_sva.sv]
`timescale 1ns/1ps
`include "gbc_regs.vh"
module gbc_bus_cmd_handler_sva (
    // clock, reset, apb qualifiers
    input wire        pclk, presetn, psel, penable, pwrite,
    // controller side
    input wire [7:0]  rx_byte, ddc_byte,
    input wire        rx_atn, rx_strobe, ren_n, cmd_exec_valid,
    // states and pulses
    input wire        ddc_strobe, talk_oe, remote, lockout, talker, listener,
    input wire        spoll_active, run_led, mem_clear, buf_ptr_rst, open_all, disp_ptr_rst, alarm_off,
    // settings
    input wire [2:0]  poles, trig_mode,
    input wire [1:0]  prog_mode,
    input wire [7:0]  first_chan, last_chan, disp_chan,
    input wire [15:0] settle_ms, interval_ms,
    input wire [23:0] alarm_time,
    input wire [3:0]  io_port
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    // command byte taken with attention true
    sequence s_cmd(logic [6:0] c);
        rx_strobe && rx_atn && rx_byte[6:0] == c;
    endsequence
    sequence s_ren_on;
        (!ren_n)[*8];
    endsequence
    sequence s_ren_off;
        ren_n[*8];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_dcl_clear: assert property (s_cmd(`GBC_CMD_DCL) |=> mem_clear && buf_ptr_rst)
        else $error("device clear left memory");
    a_dcl_defaults:
        assert property (s_cmd(`GBC_CMD_DCL) |=> poles == 3'h2 && prog_mode == 2'h0 && first_chan == 8'h01
            && last_chan == 8'h01 && disp_chan == 8'h01 && settle_ms == 16'h000a && interval_ms == 16'h000a)
        else $error("device clear defaults wrong");
    a_sdc_scope: assert property (s_cmd(`GBC_CMD_SDC) ##0 !listener |=> !mem_clear)
        else $error("unaddressed selected clear acted");
    a_sdc_clear:
        assert property (s_cmd(`GBC_CMD_SDC) ##0 listener |=> mem_clear && buf_ptr_rst && open_all
            && disp_ptr_rst && alarm_off && alarm_time == 24'h000000 && io_port == 4'h0 && disp_chan == 8'h01)
        else $error("selected clear incomplete");
    a_llo_lock: assert property (s_ren_on ##0 s_cmd(`GBC_CMD_LLO) |=> lockout)
        else $error("lockout not taken");
    a_llo_refuse: assert property (s_ren_off ##0 s_cmd(`GBC_CMD_LLO) |=> !lockout)
        else $error("lockout without remote enable");
    a_ren_release: assert property (s_ren_off |-> !remote && !lockout)
        else $error("remote kept after enable false");
    a_gtl_local:
        assert property (s_ren_on ##0 s_cmd(`GBC_CMD_GTL) ##0 listener |=> !remote && lockout == $past(lockout))
        else $error("go to local wrong");
    a_spe_enter: assert property (s_cmd(`GBC_CMD_SPE) |=> spoll_active)
        else $error("poll enable ignored");
    a_spd_exit: assert property (s_cmd(`GBC_CMD_SPD) |=> !spoll_active ##1 !talk_oe)
        else $error("poll disable ignored");
    a_poll_drive: assert property ($rose(talk_oe) |-> spoll_active && talker)
        else $error("data lines driven outside poll");
    a_untalk: assert property (s_cmd(`GBC_CMD_UNT) |=> !talker)
        else $error("untalk ignored");
    a_data_gate: assert property (rx_strobe && !rx_atn |=> ddc_strobe == $past(listener)
        && (!ddc_strobe || ddc_byte == $past(rx_byte)))
        else $error("data byte gating wrong");
    a_get_start:
        assert property (s_cmd(`GBC_CMD_GET) ##0 prog_mode == `GBC_PROG_CONT && trig_mode == `GBC_TRIG_START_GET
            && !cmd_exec_valid && !(psel && penable && pwrite) |=> run_led)
        else $error("trigger did not start");
    a_get_stop: assert property (s_cmd(`GBC_CMD_GET) ##0 trig_mode == `GBC_TRIG_STOP_GET |=> !run_led)
        else $error("trigger did not stop");
    a_exec_stop: assert property (cmd_exec_valid |=> !run_led)
        else $error("command did not stop scan");
endmodule // gbc_bus_cmd_handler_sva

bind gbc_bus_cmd_handler gbc_bus_cmd_handler_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .rx_byte(rx_byte), .rx_atn(rx_atn), .rx_strobe(rx_strobe),
    .ren_n(ren_n), .cmd_exec_valid(cmd_exec_valid), .ddc_strobe(ddc_strobe), .talk_oe(talk_oe),
    .remote(remote), .lockout(lockout), .talker(talker), .listener(listener), .spoll_active(spoll_active),
    .run_led(run_led), .mem_clear(mem_clear), .buf_ptr_rst(buf_ptr_rst), .open_all(open_all), .poles(poles),
    .trig_mode(trig_mode), .prog_mode(prog_mode), .first_chan(first_chan), .last_chan(last_chan),
    .disp_chan(disp_chan), .settle_ms(settle_ms), .interval_ms(interval_ms), .alarm_time(alarm_time),
    .io_port(io_port), .ddc_byte(ddc_byte), .disp_ptr_rst(disp_ptr_rst), .alarm_off(alarm_off));

// [sim/testbench.sv]
`timescale 1ns/1ps
`include "gbc_regs.vh"
module testbench;
    reg          pclk, presetn, psel, penable, pwrite, cmd_exec_valid;
    reg  [7:0]   paddr;
    reg  [31:0]  pwdata, v;
    wire [31:0]  prdata;
    wire [7:0]   rx_byte, talk_byte;
    wire         pready, pslverr, rx_atn, rx_strobe, atn_n, ren_n, talk_oe;
    logic [32:0] e, m, exp_q[$], msk_q[$];
    int          errors, checks_done;

    gbc_bus_cmd_handler dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_byte(rx_byte),
        .rx_atn(rx_atn), .rx_strobe(rx_strobe), .atn_n(atn_n), .ren_n(ren_n), .cmd_exec_valid(cmd_exec_valid),
        .ddc_byte(), .ddc_strobe(), .talk_byte(talk_byte), .talk_oe(talk_oe), .remote(), .lockout(), .talker(),
        .listener(), .spoll_active(), .run_led(), .mem_clear(), .buf_ptr_rst(), .disp_ptr_rst(), .open_all(),
        .alarm_off(), .poles(), .prog_mode(), .disp_mode(), .trig_mode(), .prefix_off(), .eoi_off(),
        .first_chan(), .last_chan(), .disp_chan(), .settle_ms(), .interval_ms(), .alarm_time(), .io_port(),
        .srq_mask());
    gbc_ctlr_model ctl (.pclk(pclk), .rx_byte(rx_byte), .rx_atn(rx_atn), .rx_strobe(rx_strobe),
        .atn_n(atn_n), .ren_n(ren_n));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task chk(input bit ok, input string msg);
        checks_done++;
        if (!ok) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task apb(input bit w, input [7:0] a, input [31:0] d, input [32:0] ex, input [32:0] mk);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        exp_q.push_back(ex);
        msk_q.push_back(w ? 33'h1_0000_0000 : mk); // writes: only the error flag counts
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d, 33'h0, 33'h0);
    endtask
    task rd(input [7:0] a, input [31:0] ex, input [31:0] mk);
        apb(1'b0, a, 32'h0, {1'b0, ex}, {1'b1, mk});
    endtask
    task cmd(input [7:0] b);
        ctl.send(1'b1, b, $urandom_range(0, 2));
    endtask
    // random settings, mode fields kept in a small range, channels, times and mask unrestricted
    task scramble;
        wr(`GBC_MODE_OFS, $urandom & 32'h0003_3333);
        wr(`GBC_CHAN_OFS, $urandom & 32'h00ff_ffff);
        wr(`GBC_TIME_OFS, $urandom);
        wr(`GBC_SRQ_OFS, $urandom & 32'h0000_00ff);
    endtask
    task defaults;
        rd(`GBC_MODE_OFS, 32'h0000_6002, 32'h0003_7737);
        rd(`GBC_CHAN_OFS, 32'h0001_0101, 32'h00ff_ffff);
        rd(`GBC_TIME_OFS, 32'h000a_000a, 32'hffff_ffff);
        rd(`GBC_SRQ_OFS, 32'h0, 32'hff);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // monitor: oldest note against each completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk((({pslverr, prdata} ^ e) & m) === 33'h0, "apb answer");
        end
    end
    task complete_run;
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // watchdog, well past the run's length
    initial begin
        #(40 * 20000);
        errors++;
        complete_run;
    end
    initial begin
        {psel, penable, pwrite, cmd_exec_valid, presetn, paddr, pwdata} = 45'h0;
        errors = 0;
        checks_done = 0;
        void'($urandom(32'h45785308));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        defaults;
        scramble;
        cmd({1'b0, `GBC_CMD_DCL});
        defaults;
        // lockout refused without remote enable; own address sets remote
        cmd({1'b0, `GBC_CMD_LLO});
        rd(`GBC_STAT_OFS, 32'h0, 32'h03);
        ctl.set_ren(1'b0);
        cmd(8'h31);
        rd(`GBC_STAT_OFS, 32'h49, 32'h4b);
        ctl.send(1'b0, 8'($urandom), 0);
        // selected clear for another address must be ignored
        cmd({1'b0, `GBC_CMD_UNL});
        cmd(8'h2c);
        ctl.send(1'b0, 8'($urandom), 0);
        v = $urandom & 32'h0003_3333;
        wr(`GBC_MODE_OFS, v);
        cmd({1'b0, `GBC_CMD_SDC});
        rd(`GBC_MODE_OFS, v, 32'h0003_7737);
        cmd({1'b0, `GBC_CMD_UNL});
        cmd(8'h31);
        wr(`GBC_ALARM_OFS, $urandom);
        wr(`GBC_IOPORT_OFS, $urandom);
        scramble;
        cmd({1'b0, `GBC_CMD_SDC});
        defaults;
        rd(`GBC_ALARM_OFS, 32'h0, 32'h00ff_ffff);
        rd(`GBC_IOPORT_OFS, 32'h0, 32'hf);
        // lockout survives go to local; remote enable false ends both
        cmd({1'b0, `GBC_CMD_LLO});
        rd(`GBC_STAT_OFS, 32'h4b, 32'h4b);
        cmd({1'b0, `GBC_CMD_GTL});
        rd(`GBC_STAT_OFS, 32'h4a, 32'h4b);
        ctl.set_ren(1'b1);
        rd(`GBC_STAT_OFS, 32'h0, 32'h43);
        // serial poll with an empty then a random status byte
        for (int i = 0; i < 2; i++) begin
            v = i ? ($urandom & 32'hff) : 32'h0;
            wr(`GBC_STB_OFS, v);
            ctl.poll_start(5'h11);
            for (int k = 0; k < 12 && talk_oe !== 1'b1; k++) @(negedge pclk);
            chk(talk_oe === 1'b1 && talk_byte === v[7:0], "status byte");
            rd(`GBC_STAT_OFS, 32'h14, 32'h14);
            ctl.poll_end;
            rd(`GBC_STAT_OFS, 32'h0, 32'h10);
        end
        cmd({1'b0, `GBC_CMD_UNT});
        cmd({1'b0, `GBC_CMD_UNL});
        rd(`GBC_STAT_OFS, 32'h0, 32'h0c);
        // unaddressed trigger starts, a command stops, trigger stops
        wr(`GBC_MODE_OFS, 32'h0000_2022);
        cmd({1'b0, `GBC_CMD_GET});
        rd(`GBC_STAT_OFS, 32'h20, 32'h20);
        @(posedge pclk);
        cmd_exec_valid <= 1'b1;
        @(posedge pclk);
        cmd_exec_valid <= 1'b0;
        rd(`GBC_STAT_OFS, 32'h0, 32'h20);
        wr(`GBC_MODE_OFS, 32'h0000_3022);
        wr(`GBC_CTRL_OFS, 32'h0000_0111);
        rd(`GBC_STAT_OFS, 32'h20, 32'h20);
        cmd({1'b0, `GBC_CMD_GET});
        rd(`GBC_STAT_OFS, 32'h0, 32'h20);
        wr(`GBC_CTRL_OFS, 32'h0000_0111);
        wr(`GBC_CTRL_OFS, 32'h0000_0211);
        rd(`GBC_STAT_OFS, 32'h0, 32'h20);
        // unmapped and unaligned offsets are refused
        apb(1'b0, 8'h24, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
        apb(1'b1, 8'h06, 32'hffff_ffff, 33'h1_0000_0000, 33'h0);
        rd(`GBC_CTRL_OFS, 32'h11, 32'h0000_031f);
        complete_run;
    end
endmodule // testbench
